/* File: rtl/spvel_core.sv */
// Programming-port link: executive mailbox, nvm control, Avalon-MM registers
//
// Operation
// RL1: Programmer waits 500 ns after busy clears.
// RL2: Programmer clears write enable after row write.
// RL3: Failed program sequence sets write error flag.
// RL4: Programmer reads back and compares all code.
// RL5: Protected device unreadable after a device reset.
// RL6: CRC query: command, address, length, zero word.
// RL7: Without executive, words pass through fast data.
// RL8: Programmer repeats read sequence for every location.
// RL9: 4-wire exit: all-ones mode, clear, power off.
// RL10: 2-wire exit adds one clock pulse.
// RL11: Hold interval before removing programming level.
// RL12: Programmer is master; executive never speaks unasked.
// RL13: One command, one response, collected before next.
// RL14: Programmer clock about 1 MHz recommended; the model clocks at a 160 ns period (6.25 MHz).
// RL15: Commands via fast data; replies via address/data.
// RL16: Reply ready shown by access flag, bit 18.
// RL17: Control write clearing access flag resumes processor.
// RL18: Each reply word is 32 bits.
// RL19: Data replies follow header through successive fetches.
// RL20: Response codes: pass 0, fail 2, unknown 3.
// RL21: Header holds opcode high, length low.
// RL22: CRC query opcode is 8.
`timescale 1ns/1ps
module spvel_core #(
    parameter int ROW_WRITE_CYCLES = spvel_pkg::ROW_WRITE_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [4:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic         progClockPin,
    input  wire logic         modeSelPin,
    input  wire logic         progDataPin,
    input  wire logic         masterClearPinN,
    output logic              progDataOut,
    output logic              progDataOe
);
    if (ROW_WRITE_CYCLES < 1 || ROW_WRITE_CYCLES > 65535) begin : g_bad_cycles
        $error("ROW_WRITE_CYCLES out of range");
    end

    spvel_link_if lnk ();

    spvel_tap u_tap (
        .ref_clk         (ref_clk),
        .srst            (srst),
        .progClockPin    (progClockPin),
        .modeSelPin      (modeSelPin),
        .progDataPin     (progDataPin),
        .masterClearPinN (masterClearPinN),
        .progDataOut     (progDataOut),
        .progDataOe      (progDataOe),
        .lnk             (lnk.tap)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic                   busAck;
    logic                   wrStb;
    logic                   rdStb;
    logic                   nvmBusy;
    logic                   nvmWren;
    logic                   nvmErr;
    logic [15:0]            busyCnt;
    logic                   protect;
    logic                   locked;
    logic                   clearPrev;
    logic [1:0]             ctrlEcho;
    logic                   access;
    logic [31:0]            replyWord;
    logic                   replyLast;
    logic [31:0]            cmdWord;
    logic                   cmdValid;
    logic [31:0]            lastHdr;
    logic                   overrun;
    spvel_pkg::spvel_phase_t phase;
    logic                   fastWord;
    logic                   consume;
    logic                   swReply;
    logic                   nackNow;

    // One wait cycle for every access
    assign avs_waitrequest = (avs_read || avs_write) && !busAck;
    assign wrStb           = avs_write && busAck;
    assign rdStb           = avs_read && busAck;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (avs_read || avs_write) && !busAck;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash row write control
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nvmBusy <= 1'b0;
            nvmWren <= 1'b0;
            nvmErr  <= 1'b0;
            busyCnt <= 16'h0000;
        end else begin
            if (nvmBusy) begin
                busyCnt <= busyCnt - 16'h0001;
                if (busyCnt == 16'h0001) begin
                    nvmBusy <= 1'b0;
                end
            end
            if (wrStb && avs_address == spvel_pkg::OFS_NVM_CTRL && !nvmBusy) begin
                nvmWren <= avs_writedata[spvel_pkg::NVM_WRITE_ENABLE_BIT_BIT];
                if (avs_writedata[spvel_pkg::NVM_WR_BIT]) begin
                    // Start without write enable is a failed sequence
                    if (nvmWren) begin
                        nvmBusy <= 1'b1;
                        busyCnt <= 16'(ROW_WRITE_CYCLES);
                        nvmErr  <= 1'b0;
                    end else begin
                        nvmErr  <= 1'b1; // RL3
                    end
                end else if (!avs_writedata[spvel_pkg::NVM_WRITE_ERROR_FLAG_BIT]) begin
                    nvmErr <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Code protection: a master clear with protection on locks readback
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            protect   <= 1'b0;
            locked    <= 1'b0;
            clearPrev <= 1'b0;
        end else begin
            clearPrev <= lnk.clearActive;
            if (wrStb && avs_address == spvel_pkg::OFS_CONFIG) begin
                protect <= avs_writedata[0];
            end
            if (protect && lnk.clearActive && !clearPrev) begin
                locked <= 1'b1; // RL5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Executive mailbox
    assign fastWord = lnk.updPulse && lnk.instr == spvel_pkg::IR_FASTDATA; // RL15
    assign consume  = lnk.updPulse && lnk.instr == spvel_pkg::IR_CONTROL
                      && access && !lnk.updData[spvel_pkg::ACCESS_BIT]; // RL17
    assign swReply  = wrStb && !access && phase != spvel_pkg::PH_IDLE
                      && (avs_address == spvel_pkg::OFS_REPLY
                          || avs_address == spvel_pkg::OFS_REPLY_LAST);
    assign nackNow  = fastWord && phase == spvel_pkg::PH_IDLE
                      && lnk.updData[31:16] > spvel_pkg::OP_LAST_KNOWN; // RL20 RL22

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrlEcho <= 2'b00;
        end else if (lnk.updPulse && lnk.instr == spvel_pkg::IR_CONTROL) begin
            ctrlEcho <= lnk.updData[spvel_pkg::ECHO_HI:spvel_pkg::ECHO_LO];
        end
    end

    // Commands flow in word by word; a header opens a new command
    always_ff @(posedge ref_clk) begin
        if (srst || lnk.clearActive) begin
            phase    <= spvel_pkg::PH_IDLE;
            cmdWord  <= 32'h00000000;
            cmdValid <= 1'b0;
            lastHdr  <= 32'h00000000;
            overrun  <= 1'b0;
        end else begin
            if (rdStb && avs_address == spvel_pkg::OFS_CMD_WORD) begin
                cmdValid <= 1'b0;
            end
            if (wrStb && avs_address == spvel_pkg::OFS_STATUS
                && avs_writedata[spvel_pkg::ST_OVERRUN]) begin
                overrun <= 1'b0;
            end
            if (fastWord) begin
                if (phase == spvel_pkg::PH_RESPOND || (cmdValid && !nackNow)) begin
                    overrun <= 1'b1; // RL13
                end else if (phase == spvel_pkg::PH_IDLE) begin
                    lastHdr <= lnk.updData; // RL21
                    if (nackNow) begin
                        phase <= spvel_pkg::PH_RESPOND;
                    end else begin
                        phase    <= spvel_pkg::PH_RECEIVE;
                        cmdWord  <= lnk.updData;
                        cmdValid <= 1'b1;
                    end
                end else begin
                    cmdWord  <= lnk.updData;
                    cmdValid <= 1'b1;
                end
            end
            if (swReply) begin
                phase <= spvel_pkg::PH_RESPOND;
            end
            if (consume && replyLast) begin
                phase <= spvel_pkg::PH_IDLE; // RL13
            end
        end
    end

    // Reply words only exist after a command, one per fetch
    always_ff @(posedge ref_clk) begin
        if (srst || lnk.clearActive) begin
            access    <= 1'b0;
            replyWord <= 32'h00000000;
            replyLast <= 1'b0;
        end else if (nackNow) begin
            access    <= 1'b1; // RL12
            replyWord <= {lnk.updData[31:16], spvel_pkg::RESP_NACK}; // RL20
            replyLast <= 1'b1;
        end else if (swReply) begin
            access    <= 1'b1; // RL19
            replyWord <= avs_writedata; // RL18
            replyLast <= avs_address == spvel_pkg::OFS_REPLY_LAST;
        end else if (consume) begin
            access <= 1'b0; // RL16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Words captured into the test-port shifter
    always_comb begin
        case (lnk.instr)
            spvel_pkg::IR_CONTROL: begin
                lnk.capData = 32'h00000000;
                lnk.capData[spvel_pkg::ACCESS_BIT] = access; // RL16
                lnk.capData[spvel_pkg::ECHO_HI:spvel_pkg::ECHO_LO] = ctrlEcho;
            end
            spvel_pkg::IR_DATA:     lnk.capData = locked ? 32'h00000000 : replyWord; // RL5
            spvel_pkg::IR_FASTDATA: lnk.capData = locked ? 32'h00000000 : replyWord;
            default:                lnk.capData = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !busAck) begin
            case (avs_address)
                spvel_pkg::OFS_NVM_CTRL: avs_readdata <= {16'h0000, nvmBusy, nvmWren, nvmErr,
                                                          13'h0000};
                spvel_pkg::OFS_CONFIG:   avs_readdata <= {31'h00000000, protect};
                spvel_pkg::OFS_STATUS:   avs_readdata <= {26'h0000000,
                                                          phase == spvel_pkg::PH_RESPOND,
                                                          phase != spvel_pkg::PH_IDLE,
                                                          overrun, locked, access, cmdValid};
                spvel_pkg::OFS_CMD_WORD: avs_readdata <= cmdWord;
                spvel_pkg::OFS_LAST_HDR: avs_readdata <= lastHdr;
                default:                 avs_readdata <= 32'h00000000;
            endcase
        end
    end
endmodule // spvel_core

/* File: rtl/spvel_pkg.sv */
// Shared constants and types for the programming-port link block
package spvel_pkg;
    // Timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int ROW_WRITE_NS  = 20_000;
    localparam int ROW_WRITE_CYC = (ROW_WRITE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Debug test port instruction codes
    localparam int          IR_W        = 5;
    localparam logic [4:0]  IR_ADDRESS  = 5'h08;
    localparam logic [4:0]  IR_DATA     = 5'h09;
    localparam logic [4:0]  IR_CONTROL  = 5'h0A;
    localparam logic [4:0]  IR_FASTDATA = 5'h0E;
    localparam logic [4:0]  IR_BYPASS   = 5'h1F;
    localparam logic [31:0] IR_CAPTURE  = 32'h00000001;

    // Control word layout
    localparam int ACCESS_BIT = 18;
    localparam int ECHO_HI    = 15;
    localparam int ECHO_LO    = 14;

    // Register byte offsets on the bus
    localparam logic [4:0] OFS_NVM_CTRL   = 5'h00;
    localparam logic [4:0] OFS_CONFIG     = 5'h04;
    localparam logic [4:0] OFS_STATUS     = 5'h08;
    localparam logic [4:0] OFS_CMD_WORD   = 5'h0C;
    localparam logic [4:0] OFS_REPLY      = 5'h10;
    localparam logic [4:0] OFS_LAST_HDR   = 5'h14;
    localparam logic [4:0] OFS_REPLY_LAST = 5'h18;

    // nvm_control_reg fields
    localparam int NVM_WR_BIT    = 15;
    localparam int NVM_WRITE_ENABLE_BIT_BIT  = 14;
    localparam int NVM_WRITE_ERROR_FLAG_BIT = 13;

    // Status fields
    localparam int ST_CMD_VALID = 0;
    localparam int ST_ACCESS    = 1;
    localparam int ST_LOCKED    = 2;
    localparam int ST_OVERRUN   = 3;
    localparam int ST_IN_CMD    = 4;
    localparam int ST_RESPOND   = 5;

    // Executive opcodes and response codes
    localparam logic [15:0] OP_GET_CRC   = 16'h0008;
    localparam logic [15:0] OP_LAST_KNOWN = 16'h0008;
    localparam logic [15:0] RESP_PASS    = 16'h0000;
    localparam logic [15:0] RESP_FAIL    = 16'h0002;
    localparam logic [15:0] RESP_NACK    = 16'h0003;

    typedef enum logic [3:0] {
        TAP_RESET   = 4'h0,
        TAP_IDLE    = 4'h1,
        TAP_SEL_DR  = 4'h2,
        TAP_CAP_DR  = 4'h3,
        TAP_SH_DR   = 4'h4,
        TAP_EX1_DR  = 4'h5,
        TAP_PAU_DR  = 4'h6,
        TAP_EX2_DR  = 4'h7,
        TAP_UPD_DR  = 4'h8,
        TAP_SEL_IR  = 4'h9,
        TAP_CAP_IR  = 4'hA,
        TAP_SH_IR   = 4'hB,
        TAP_EX1_IR  = 4'hC,
        TAP_PAU_IR  = 4'hD,
        TAP_EX2_IR  = 4'hE,
        TAP_UPD_IR  = 4'hF
    } spvel_tap_t;

    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_RECEIVE = 2'b01,
        PH_RESPOND = 2'b10
    } spvel_phase_t;
endpackage

/* File: rtl/spvel_link_if.sv */
// Carrier between the test-port shifter and the executive mailbox
`timescale 1ns/1ps
interface spvel_link_if;
    logic [4:0]  instr;
    logic [31:0] capData;
    logic        updPulse;
    logic [31:0] updData;
    logic        clearActive;

    modport tap  (output instr, output updPulse, output updData, output clearActive,
                  input capData);
    modport core (input instr, input updPulse, input updData, input clearActive,
                  output capData);
endinterface

/* File: rtl/spvel_tap.sv */
// Test-port state machine and shifter, sampling the programmer's pins
`timescale 1ns/1ps
module spvel_tap (
    input  wire logic   ref_clk,
    input  wire logic   srst,
    input  wire logic   progClockPin,
    input  wire logic   modeSelPin,
    input  wire logic   progDataPin,
    input  wire logic   masterClearPinN,
    output logic        progDataOut,
    output logic        progDataOe,
    spvel_link_if.tap   lnk
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic spvel_pkg::spvel_tap_t tapNext(spvel_pkg::spvel_tap_t s, logic m);
        case (s)
            spvel_pkg::TAP_RESET:  tapNext = m ? spvel_pkg::TAP_RESET  : spvel_pkg::TAP_IDLE;
            spvel_pkg::TAP_IDLE:   tapNext = m ? spvel_pkg::TAP_SEL_DR : spvel_pkg::TAP_IDLE;
            spvel_pkg::TAP_SEL_DR: tapNext = m ? spvel_pkg::TAP_SEL_IR : spvel_pkg::TAP_CAP_DR;
            spvel_pkg::TAP_CAP_DR: tapNext = m ? spvel_pkg::TAP_EX1_DR : spvel_pkg::TAP_SH_DR;
            spvel_pkg::TAP_SH_DR:  tapNext = m ? spvel_pkg::TAP_EX1_DR : spvel_pkg::TAP_SH_DR;
            spvel_pkg::TAP_EX1_DR: tapNext = m ? spvel_pkg::TAP_UPD_DR : spvel_pkg::TAP_PAU_DR;
            spvel_pkg::TAP_PAU_DR: tapNext = m ? spvel_pkg::TAP_EX2_DR : spvel_pkg::TAP_PAU_DR;
            spvel_pkg::TAP_EX2_DR: tapNext = m ? spvel_pkg::TAP_UPD_DR : spvel_pkg::TAP_SH_DR;
            spvel_pkg::TAP_UPD_DR: tapNext = m ? spvel_pkg::TAP_SEL_DR : spvel_pkg::TAP_IDLE;
            spvel_pkg::TAP_SEL_IR: tapNext = m ? spvel_pkg::TAP_RESET  : spvel_pkg::TAP_CAP_IR;
            spvel_pkg::TAP_CAP_IR: tapNext = m ? spvel_pkg::TAP_EX1_IR : spvel_pkg::TAP_SH_IR;
            spvel_pkg::TAP_SH_IR:  tapNext = m ? spvel_pkg::TAP_EX1_IR : spvel_pkg::TAP_SH_IR;
            spvel_pkg::TAP_EX1_IR: tapNext = m ? spvel_pkg::TAP_UPD_IR : spvel_pkg::TAP_PAU_IR;
            spvel_pkg::TAP_PAU_IR: tapNext = m ? spvel_pkg::TAP_EX2_IR : spvel_pkg::TAP_PAU_IR;
            spvel_pkg::TAP_EX2_IR: tapNext = m ? spvel_pkg::TAP_UPD_IR : spvel_pkg::TAP_SH_IR;
            spvel_pkg::TAP_UPD_IR: tapNext = m ? spvel_pkg::TAP_SEL_DR : spvel_pkg::TAP_IDLE;
            default:               tapNext = spvel_pkg::TAP_RESET;
        endcase
    endfunction

    logic [3:0]          syncA;
    logic [3:0]          syncB;
    logic                clkPrev;
    logic                clkRise;
    logic                clkFall;
    logic                tmsS;
    logic                tdiS;
    spvel_pkg::spvel_tap_t state;
    logic [31:0]         drShift;
    logic [4:0]          irShift;

    ////////////////////////////////////////////////////////////////////////////
    // Pins cross into ref_clk through two flops
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            syncA   <= 4'h1;
            syncB   <= 4'h1;
            clkPrev <= 1'b0;
        end else begin
            syncA   <= {progClockPin, modeSelPin, progDataPin, masterClearPinN};
            syncB   <= syncA;
            clkPrev <= syncB[3];
        end
    end

    assign clkRise = syncB[3] & ~clkPrev;
    assign clkFall = ~syncB[3] & clkPrev;
    assign tmsS    = syncB[2];
    assign tdiS    = syncB[1];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lnk.clearActive <= 1'b1;
        end else begin
            lnk.clearActive <= ~syncB[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Five rising edges with mode select high always end in reset
    always_ff @(posedge ref_clk) begin
        if (srst || lnk.clearActive) begin
            state <= spvel_pkg::TAP_RESET;
        end else if (clkRise) begin
            state <= tapNext(state, tmsS);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || lnk.clearActive || state == spvel_pkg::TAP_RESET) begin
            lnk.instr <= spvel_pkg::IR_BYPASS;
            irShift   <= 5'h00;
        end else if (clkRise) begin
            case (state)
                spvel_pkg::TAP_CAP_IR: irShift   <= spvel_pkg::IR_CAPTURE[4:0];
                spvel_pkg::TAP_SH_IR:  irShift   <= {tdiS, irShift[4:1]};
                spvel_pkg::TAP_UPD_IR: lnk.instr <= irShift;
                default:               irShift   <= irShift;
            endcase
        end
    end

    // Update acts on the rising edge that leaves the update state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drShift      <= 32'h00000000;
            lnk.updPulse <= 1'b0;
            lnk.updData  <= 32'h00000000;
        end else begin
            lnk.updPulse <= 1'b0;
            if (clkRise) begin
                case (state)
                    spvel_pkg::TAP_CAP_DR: drShift <= lnk.capData;
                    spvel_pkg::TAP_SH_DR:  drShift <= {tdiS, drShift[31:1]};
                    spvel_pkg::TAP_UPD_DR: begin
                        lnk.updPulse <= 1'b1;
                        lnk.updData  <= drShift;
                    end
                    default:               drShift <= drShift;
                endcase
            end
        end
    end

    // Output changes on the falling link edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            progDataOut <= 1'b0;
            progDataOe  <= 1'b0;
        end else if (clkFall) begin
            progDataOut <= (state == spvel_pkg::TAP_SH_IR) ? irShift[0] : drShift[0];
            progDataOe  <= (state == spvel_pkg::TAP_SH_IR) || (state == spvel_pkg::TAP_SH_DR);
        end
    end
endmodule // spvel_tap

/* File: tb/spvel_core_assertions.sv */
// Port checks for the programming-port link block
`timescale 1ns/1ps
module spvel_core_assertions (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        progClockPin,
    input wire logic        masterClearPinN,
    input wire logic        progDataOut,
    input wire logic        progDataOe
);
    logic reqOn;
    assign reqOn = avs_read | avs_write;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_req_rise; $rose(reqOn); endsequence
    sequence s_clear_held; !masterClearPinN [*8]; endsequence
    // Outputs only move on a detected link edge
    sequence s_link_still; ($stable(progClockPin) && masterClearPinN) [*6]; endsequence
    property p_wait_first; s_req_rise |-> avs_waitrequest; endproperty
    property p_wait_one; s_req_rise |=> !avs_waitrequest; endproperty
    property p_wait_cause; avs_waitrequest |-> reqOn; endproperty
    property p_rdata_cause; $changed(avs_readdata) |-> $past(avs_read); endproperty
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address == 5'h1C |=> avs_readdata == 32'h00000000;
    endproperty
    property p_reset_out; $fell(srst) |-> !progDataOe && avs_readdata == 32'h00000000; endproperty
    property p_clear_oe; s_clear_held |-> !progDataOe; endproperty
    property p_out_still; s_link_still |-> $stable(progDataOut) && $stable(progDataOe); endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
    a_wait_one: assert property (p_wait_one) else $error("wait too long");
    a_wait_cause: assert property (p_wait_cause) else $error("wait while idle");
    a_rdata_cause: assert property (p_rdata_cause) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    a_reset_out: assert property (p_reset_out) else $error("reset values wrong");
    a_clear_oe: assert property (p_clear_oe) else $error("driven in clear");
    a_out_still: assert property (p_out_still) else $error("output moved");
endmodule // spvel_core_assertions
bind spvel_core spvel_core_assertions spvel_core_assertions_i (.*);

/* File: tb/spvel_prog_model.sv */
// Programmer tool model driving the link pins
`timescale 1ns/1ps
module spvel_prog_model #(
    parameter int HOLD_CYCLES = 10
) (
    input  wire logic ref_clk,
    input  wire logic progDataOut,
    output logic      progClockPin,
    output logic      modeSelPin,
    output logic      progDataPin,
    output logic      masterClearPinN
);
    initial {progClockPin, modeSelPin, progDataPin, masterClearPinN} = 4'h5;
    // One 160 ns link period, entered right after a rising edge
    task automatic tck(input logic tms, input logic tdi, output logic tdo);
        modeSelPin <= tms;
        progDataPin <= tdi;
        repeat (4) @(posedge ref_clk);
        progClockPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tdo = progDataOut;
        @(posedge ref_clk);
        progClockPin <= 1'b0;
    endtask
    task automatic shift(input logic ir, input logic [31:0] d, input int n,
                         output logic [31:0] q);
        logic b;
        q = '0;
        @(posedge ref_clk);
        tck(1'b1, 1'b0, b);
        if (ir)
            tck(1'b1, 1'b0, b);
        repeat (2) tck(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            tck(i == n - 1, d[i], b);
            q[i] = b;
        end
        tck(1'b1, 1'b0, b);
        // Released data line shows the inverse of its last bit
        tck(1'b0, ~d[n - 1], b);
    endtask
    task automatic go_idle();
        logic b;
        @(posedge ref_clk);
        repeat (5) tck(1'b1, 1'b0, b);
        tck(1'b0, 1'b0, b);
    endtask
    task automatic fast(input logic [31:0] w);
        logic [31:0] c;
        shift(1'b1, {27'h0000000, spvel_pkg::IR_FASTDATA}, 5, c);
        shift(1'b0, w, 32, c);
    endtask
    task automatic ctl(output logic [31:0] c);
        shift(1'b1, {27'h0000000, spvel_pkg::IR_CONTROL}, 5, c);
        shift(1'b0, 32'h0004C000, 32, c);
    endtask
    task automatic fetch(output logic [31:0] r);
        logic [31:0] c;
        ctl(c);
        for (int k = 0; k < 20 && c[spvel_pkg::ACCESS_BIT] !== 1'b1; k++)
            ctl(c);
        shift(1'b1, {27'h0000000, spvel_pkg::IR_DATA}, 5, c);
        shift(1'b0, 32'h00000000, 32, r);
        shift(1'b1, {27'h0000000, spvel_pkg::IR_CONTROL}, 5, c);
        shift(1'b0, 32'h0000C000, 32, c);
    endtask
    task automatic leave();
        logic b;
        @(posedge ref_clk);
        repeat (5) tck(1'b1, 1'b0, b);
        repeat (HOLD_CYCLES) @(posedge ref_clk);
        masterClearPinN <= 1'b0;
        repeat (8) @(posedge ref_clk);
        progClockPin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        progClockPin <= 1'b0;
    endtask
endmodule // spvel_prog_model

/* File: tb/spvel_core_tb_top.sv */
// Self-checking bench for the programming-port link block
`timescale 1ns/1ps
module spvel_core_tb_top;
    logic        ref_clk, srst;
    logic [4:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        progClockPin, modeSelPin, progDataPin, masterClearPinN;
    logic        progDataOut, progDataOe;
    logic [31:0] q;
    logic [31:0] cmd [4] = '{32'h00080002, 32'h1D000000, 32'h00000100, 32'h00000000};
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    spvel_core #(.ROW_WRITE_CYCLES(10)) spvel_core_i (.*);
    spvel_prog_model spvel_prog_model_i (.*);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Held until waitrequest is seen low at a rising edge; only the timeout ends a hang
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        avs_address = 5'h00;
        {avs_read, avs_write} = 2'b00;
        avs_writedata = 32'h00000000;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(5'h00, 32'h00000000);
        rd(5'h04, 32'h00000000);
        rd(5'h08, 32'h00000000);
        rd(5'h1C, 32'h00000000);
        $display("test reset values done");
        bus(1'b1, 5'h00, 32'h00008000);
        rd(5'h00, 32'h00002000);
        bus(1'b1, 5'h00, 32'h00000000);
        rd(5'h00, 32'h00000000);
        bus(1'b1, 5'h00, 32'h00004000);
        bus(1'b1, 5'h00, 32'h0000C000);
        rd(5'h00, 32'h0000C000);
        for (int k = 0; k < 10 && q !== 32'h00004000; k++)
            bus(1'b0, 5'h00, 32'h00000000);
        chk(q, 32'h00004000);
        repeat (25) @(posedge ref_clk);
        bus(1'b1, 5'h00, 32'h00000000);
        rd(5'h00, 32'h00000000);
        $display("test row write done");
        spvel_prog_model_i.go_idle();
        bus(1'b1, 5'h10, 32'h00080000);
        spvel_prog_model_i.ctl(q);
        chk(32'(q[18]), 32'h00000000);
        foreach (cmd[i]) begin
            spvel_prog_model_i.fast(cmd[i]);
            rd(5'h0C, cmd[i]);
        end
        bus(1'b1, 5'h10, 32'h00080000);
        spvel_prog_model_i.fetch(q);
        chk(q, 32'h00080000);
        bus(1'b1, 5'h18, 32'h5A5AC3C3);
        spvel_prog_model_i.fetch(q);
        chk(q, 32'h5A5AC3C3);
        rd(5'h08, 32'h00000000);
        spvel_prog_model_i.fast(32'h00090002);
        spvel_prog_model_i.fetch(q);
        chk(q, 32'h00090003);
        $display("test executive done");
        bus(1'b1, 5'h04, 32'h00000001);
        spvel_prog_model_i.leave();
        rd(5'h08, 32'h00000004);
        $display("test exit done");
        end_sim();
    end
endmodule // spvel_core_tb_top
